// ### verilog/light_pkg.sv
// constants for the light sensor readout block
package light_pkg;
	localparam logic [7:0] cfg_offset = 8'h00;
	localparam logic [7:0] result_offset = 8'h04;
	localparam int it_hi = 9;
	localparam int it_lo = 6;
	localparam int gain_hi = 12;
	localparam int gain_lo = 11;
	localparam int shutdown_bit = 0;
	localparam logic [15:0] cfg_reset = 16'h0001;
	localparam logic [15:0] cfg_write_mask = 16'h1fff;
	localparam logic [3:0] it_25 = 4'hc;
	localparam logic [3:0] it_50 = 4'h8;
	localparam logic [3:0] it_100 = 4'h0;
	localparam logic [3:0] it_200 = 4'h1;
	localparam logic [3:0] it_400 = 4'h2;
	localparam logic [3:0] it_800 = 4'h3;
	localparam logic [1:0] gain_x1 = 2'h0;
	localparam logic [1:0] gain_x2 = 2'h1;
	localparam logic [1:0] gain_x1_8 = 2'h2;
	localparam logic [1:0] gain_x1_4 = 2'h3;
	localparam int clk_mhz = 125;
	localparam int wake_us_x10 = 25000;
	localparam int wake_cycles = wake_us_x10 * clk_mhz / 10;
	localparam int it_base_ms = 25;
	localparam int it_base_cycles = it_base_ms * clk_mhz * 1000;
	typedef enum logic [1:0] {st_off, st_wake, st_integ} meas_state_type;
endpackage

// ### verilog/period_lookup.sv
// maps integration code to a multiple of the 25 ms base period
module period_lookup
	import light_pkg::*;
(
	input wire logic [3:0] code,
	output logic [5:0] mult,
	output logic valid
);
	always_comb begin
		valid = 1'b1;
		case (code)
			it_25: mult = 6'd1;
			it_50: mult = 6'd2;
			it_100: mult = 6'd4;
			it_200: mult = 6'd8;
			it_400: mult = 6'd16;
			it_800: mult = 6'd32;
			default: begin
				mult = 6'd4;
				valid = 1'b0;
			end
		endcase
	end
endmodule

// ### verilog/light_readout.sv
// register file and measurement sequencing of the ambient light readout
//
// Behaviour
// - integration code in config bits 9..6
// - 16-bit result at command 04, read-only
// - result kept and readable during shutdown
// - result refreshed after wake by measurements
// - gain code in bits 12..11, 15..13 zero
// - bit 0 shutdown, default set, 2.5 ms wake
module light_readout
	import light_pkg::*;
#(
	parameter int wake_count = wake_cycles,
	parameter int base_count = it_base_cycles
)
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] cmd_code,
	input wire logic [15:0] wr_data,
	input wire logic [15:0] sample,
	output logic [15:0] rd_data,
	output logic rd_valid,
	output logic shutdown_ctrl,
	output logic [1:0] gain_sel,
	output logic [3:0] integration_period_sel,
	output logic result_fresh
);
	logic [15:0] light_config_q, light_config_d;
	logic [15:0] light_result_q, light_result_d;
	logic [15:0] rd_data_q, rd_data_d;
	logic rd_valid_q, rd_valid_d;
	logic fresh_q, fresh_d;
	meas_state_type state_q, state_d;
	logic [31:0] timer_q, timer_d;
	logic [31:0] period_count;
	logic [5:0] mult;
	logic it_valid;
	logic [15:0] sample_s1_q, sample_s2_q, sample_s3_q;
	logic [15:0] sample_hold_q, sample_hold_d;

	period_lookup u_lookup (
		.code(light_config_q[it_hi:it_lo]),
		.mult(mult),
		.valid(it_valid)
	);

	assign period_count = 32'(base_count) * 32'(mult);

	always_comb begin
		light_config_d = light_config_q;
		light_result_d = light_result_q;
		rd_data_d = rd_data_q;
		rd_valid_d = 1'b0;
		fresh_d = 1'b0;
		state_d = state_q;
		timer_d = timer_q;
		// take the converter word only once two synchronised copies agree,
		// so a word caught while its bits change is never stored
		sample_hold_d = sample_hold_q;
		if (sample_s2_q == sample_s3_q) begin
			sample_hold_d = sample_s2_q;
		end
		if (wr_en && cmd_code == cfg_offset) begin
			light_config_d = wr_data & cfg_write_mask;
		end
		if (rd_en) begin
			rd_valid_d = 1'b1;
			if (cmd_code == result_offset) begin
				rd_data_d = light_result_q;
			end else begin
				rd_data_d = 16'h0000;
			end
		end
		case (state_q)
			st_off: begin
				timer_d = 32'd0;
				if (!light_config_q[shutdown_bit]) begin
					state_d = st_wake;
				end
			end
			st_wake: begin
				timer_d = timer_q + 32'd1;
				if (light_config_q[shutdown_bit]) begin
					state_d = st_off;
				end else if (timer_q >= 32'(wake_count) - 32'd1) begin
					state_d = st_integ;
					timer_d = 32'd0;
				end
			end
			default: begin
				timer_d = timer_q + 32'd1;
				if (light_config_q[shutdown_bit]) begin
					state_d = st_off; // result kept as is
				end else if (timer_q >= period_count - 32'd1) begin
					light_result_d = sample_hold_q;
					fresh_d = it_valid;
					timer_d = 32'd0;
				end
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		sample_s1_q <= sample;
		sample_s2_q <= sample_s1_q;
		sample_s3_q <= sample_s2_q;
		if (rst) begin
			light_config_q <= cfg_reset;
			light_result_q <= 16'h0000;
			rd_data_q <= 16'h0000;
			rd_valid_q <= 1'b0;
			fresh_q <= 1'b0;
			state_q <= st_off;
			timer_q <= 32'd0;
			sample_hold_q <= 16'h0000;
		end else begin
			light_config_q <= light_config_d;
			light_result_q <= light_result_d;
			rd_data_q <= rd_data_d;
			rd_valid_q <= rd_valid_d;
			fresh_q <= fresh_d;
			state_q <= state_d;
			timer_q <= timer_d;
			sample_hold_q <= sample_hold_d;
		end
	end

	assign rd_data = rd_data_q;
	assign rd_valid = rd_valid_q;
	assign shutdown_ctrl = light_config_q[shutdown_bit];
	assign gain_sel = light_config_q[gain_hi:gain_lo];
	assign integration_period_sel = light_config_q[it_hi:it_lo];
	assign result_fresh = fresh_q;

	property p_shutdown_keeps;
		@(posedge mclk) disable iff (rst)
		(state_q == st_off && !(wr_en && cmd_code == cfg_offset)) |=> $stable(light_result_q);
	endproperty
	a_shutdown_keeps: assert property (p_shutdown_keeps) else $error("result changed in shutdown");

	property p_read_result;
		@(posedge mclk) disable iff (rst)
		(rd_en && cmd_code == result_offset) |=> (rd_valid_q && rd_data_q == $past(light_result_q));
	endproperty
	a_read_result: assert property (p_read_result) else $error("result read mismatch");

	property p_reserved_zero;
		@(posedge mclk) disable iff (rst)
		light_config_q[15:13] == 3'h0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

	property p_wake_first;
		@(posedge mclk) disable iff (rst)
		(state_q == st_off && !light_config_q[shutdown_bit]) |=> state_q == st_wake;
	endproperty
	a_wake_first: assert property (p_wake_first) else $error("wake delay skipped");

	property p_fresh_in_integ;
		@(posedge mclk) disable iff (rst)
		fresh_q |-> ($past(state_q) == st_integ && light_result_q == $past(sample_hold_q));
	endproperty
	a_fresh_in_integ: assert property (p_fresh_in_integ) else $error("refresh outside run");

	property p_enter_off;
		@(posedge mclk) disable iff (rst)
		(light_config_q[shutdown_bit] && state_q != st_off) |=> state_q == st_off;
	endproperty
	a_enter_off: assert property (p_enter_off) else $error("shutdown not entered");

	property p_fields;
		@(posedge mclk) disable iff (rst)
		(wr_en && cmd_code == cfg_offset) |=> (integration_period_sel == $past(wr_data[9:6])
			&& gain_sel == $past(wr_data[12:11]));
	endproperty
	a_fields: assert property (p_fields) else $error("config fields wrong");

	property p_unmapped;
		@(posedge mclk) disable iff (rst)
		(rd_en && cmd_code != result_offset) |=> rd_data_q == 16'h0000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");

	property p_hold_filter;
		@(posedge mclk) disable iff (rst)
		(sample_s2_q != sample_s3_q) |=> $stable(sample_hold_q);
	endproperty
	a_hold_filter: assert property (p_hold_filter) else $error("unsettled sample taken");

	property p_wake_keeps;
		@(posedge mclk) disable iff (rst)
		(state_q == st_wake) |=> $stable(light_result_q);
	endproperty
	a_wake_keeps: assert property (p_wake_keeps) else $error("result changed in wake");

	property p_wake_len;
		@(posedge mclk) disable iff (rst)
		(state_q == st_wake && timer_q < 32'(wake_count) - 32'd1 && !light_config_q[shutdown_bit])
			|=> state_q == st_wake;
	endproperty
	a_wake_len: assert property (p_wake_len) else $error("wake time cut short");

	property p_reserved_quiet;
		@(posedge mclk) disable iff (rst)
		!it_valid |=> !fresh_q;
	endproperty
	a_reserved_quiet: assert property (p_reserved_quiet) else $error("fresh on reserved code");

	property p_rd_pulse;
		@(posedge mclk) disable iff (rst)
		rd_valid_q |-> $past(rd_en);
	endproperty
	a_rd_pulse: assert property (p_rd_pulse) else $error("read valid without request");

	property p_config_hold;
		@(posedge mclk) disable iff (rst)
		!(wr_en && cmd_code == cfg_offset) |=> $stable(light_config_q);
	endproperty
	a_config_hold: assert property (p_config_hold) else $error("config changed unasked");
endmodule

// ### bench/host_model.sv
// host controller model driving the command-register strobes
module host_model
	import light_pkg::*;
#(
	// one 25 ms step and the wake time, in clocks of the readout under test
	parameter int step_cycles = 4,
	parameter int wake_wait = 10
)
(
	input wire logic mclk,
	input wire logic [15:0] rd_data,
	input wire logic rd_valid,
	output logic wr_en,
	output logic rd_en,
	output logic [7:0] cmd_code,
	output logic [15:0] wr_data
);
	timeunit 1ns;
	timeprecision 1ps;
	// lowest gain, 100 ms period, powered on
	localparam logic [15:0] start_cfg = 16'h1000;
	initial begin
		wr_en = 1'b0;
		rd_en = 1'b0;
		cmd_code = 8'h00;
		wr_data = 16'h0000;
	end
	task automatic put(input logic [7:0] c, input logic [15:0] d);
		@(negedge mclk);
		wr_en = 1'b1;
		cmd_code = c;
		wr_data = d;
		@(posedge mclk);
		@(negedge mclk);
		wr_en = 1'b0;
		wr_data = ~d;
	endtask
	task automatic get(input logic [7:0] c, output logic [15:0] d, output logic v);
		@(negedge mclk);
		rd_en = 1'b1;
		cmd_code = c;
		@(posedge mclk);
		@(negedge mclk);
		rd_en = 1'b0;
		d = rd_data;
		v = rd_valid;
	endtask
	// integration period as a multiple of 25 ms; zero for a reserved code
	function automatic int mult_of(input logic [3:0] it);
		case (it)
			it_25: return 1;
			it_50: return 2;
			it_100: return 4;
			it_200: return 8;
			it_400: return 16;
			it_800: return 32;
			default: return 0;
		endcase
	endfunction
	// resolution in 0.0001 lx per count; zero flags a reserved period code
	function automatic int factor_of(input logic [1:0] g, input logic [3:0] it);
		int f;
		f = 0;
		if (mult_of(it) != 0) begin
			f = 36 * 32 / mult_of(it);
		end
		case (g)
			gain_x1: f = f * 2;
			gain_x1_4: f = f * 8;
			gain_x1_8: f = f * 16;
			default: f = f;
		endcase
		return f;
	endfunction
	// lux in 0.0001 lx units
	function automatic int lux_of(input logic [15:0] c, input logic [1:0] g, input logic [3:0] it);
		return int'(c) * factor_of(g, it);
	endfunction
	// highest lux before full scale, rounded
	function automatic int limit_of(input logic [1:0] g, input logic [3:0] it);
		return (65535 * factor_of(g, it) + 5000) / 10000;
	endfunction
	function automatic logic needs_comp(input logic [15:0] c, input logic [1:0] g,
		input logic [3:0] it);
		return lux_of(c, g, it) > 10000000;
	endfunction
	// gain ladder from lowest to highest: 1/8, 1/4, 1, 2
	function automatic logic [1:0] raise_gain(input logic [1:0] g);
		case (g)
			gain_x1_8: return gain_x1_4;
			gain_x1_4: return gain_x1;
			default: return gain_x2;
		endcase
	endfunction
	function automatic logic [1:0] lower_gain(input logic [1:0] g);
		case (g)
			gain_x2: return gain_x1;
			gain_x1: return gain_x1_4;
			default: return gain_x1_8;
		endcase
	endfunction
	function automatic logic [3:0] longer(input logic [3:0] it);
		case (it)
			it_100: return it_200;
			it_200: return it_400;
			default: return it_800;
		endcase
	endfunction
	function automatic logic [3:0] shorter(input logic [3:0] it);
		case (it)
			it_800: return it_400;
			it_400: return it_200;
			it_200: return it_100;
			it_100: return it_50;
			default: return it_25;
		endcase
	endfunction
	// wake time, then two periods so that one whole period ran on the new range
	task automatic settle(input logic [3:0] it);
		repeat (wake_wait + 2 * step_cycles * mult_of(it) + 8) @(negedge mclk);
	endtask
	// steps gain then period on the 100-count threshold, backs off on full scale
	task automatic autorange(output logic [1:0] g, output logic [3:0] it, output logic [15:0] c);
		logic v;
		logic done;
		g = gain_x1_8;
		it = it_100;
		done = 1'b0;
		while (!done) begin
			put(cfg_offset, {3'h0, g, 1'b0, it, 6'h00});
			settle(it);
			get(result_offset, c, v);
			done = 1'b1;
			if (c == 16'hffff && g != gain_x1_8) begin
				g = lower_gain(g);
				done = 1'b0;
			end else if (c == 16'hffff && it != it_25) begin
				it = shorter(it);
				done = 1'b0;
			end else if (c <= 16'd100 && g != gain_x2 && lux_of(c, g, it) < 1000000) begin
				g = raise_gain(g);
				done = 1'b0;
			end else if (c <= 16'd100 && g == gain_x2 && it != it_800) begin
				it = longer(it);
				done = 1'b0;
			end
		end
	endtask
endmodule

// ### bench/tb.sv
// testbench of the light readout block
module tb import light_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int sim_step = 4;
	localparam int sim_wake = 10;
	logic mclk, rst, wr_en, rd_en, rd_valid, shutdown_ctrl, result_fresh, v;
	logic [7:0] cmd_code;
	logic [15:0] wr_data, sample, rd_data, d;
	logic [1:0] g;
	logic [3:0] itc;
	logic [1:0] gain_sel;
	logic [3:0] integration_period_sel;
	int fail_count = 0;
	int checked = 0;
	int n;
	logic [3:0] codes [6] = '{it_25, it_50, it_100, it_200, it_400, it_800};
	int mults [6] = '{1, 2, 4, 8, 16, 32};
	light_readout #(.wake_count(sim_wake), .base_count(sim_step)) dut (.mclk(mclk), .rst(rst),
		.wr_en(wr_en), .rd_en(rd_en), .cmd_code(cmd_code), .wr_data(wr_data),
		.sample(sample), .rd_data(rd_data), .rd_valid(rd_valid),
		.shutdown_ctrl(shutdown_ctrl), .gain_sel(gain_sel),
		.integration_period_sel(integration_period_sel), .result_fresh(result_fresh));
	host_model #(.step_cycles(sim_step), .wake_wait(sim_wake)) host (.mclk(mclk),
		.rd_data(rd_data), .rd_valid(rd_valid),
		.wr_en(wr_en), .rd_en(rd_en), .cmd_code(cmd_code), .wr_data(wr_data));
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wait_fresh(output int c);
		c = 0;
		do begin
			@(negedge mclk);
			c++;
		end while (result_fresh !== 1'b1 && c < 400);
	endtask
	task automatic complete_run;
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge mclk);
		fail_count++;
		$display("[FAIL] %0t watchdog expired", $time);
		complete_run;
	end
	initial begin
		rst = 1'b1;
		sample = 16'h5ac3;
		repeat (8) @(posedge mclk);
		@(negedge mclk);
		rst = 1'b0;
		chk(16'(shutdown_ctrl), 16'h0001);
		host.get(result_offset, d, v);
		chk(d, 16'h0000);
		chk(16'(v), 16'h0001);
		host.put(cfg_offset, 16'he000 | host.start_cfg);
		chk(16'({gain_sel, integration_period_sel, shutdown_ctrl}), {9'h0, gain_x1_8, it_100, 1'b0});
		// a write to the read-only result must not touch the config
		host.put(result_offset, 16'h0001);
		chk(16'(shutdown_ctrl), 16'h0000);
		wait_fresh(n);
		chk(16'(n < 400), 16'h0001);
		host.get(result_offset, d, v);
		chk(d, 16'h5ac3);
		foreach (codes[i]) begin
			host.put(cfg_offset, {3'h0, gain_x2, 1'b0, codes[i], 6'h00});
			chk(16'(integration_period_sel), 16'(codes[i]));
			chk(16'(gain_sel), 16'(gain_x2));
			wait_fresh(n);
			wait_fresh(n);
			chk(16'(n), 16'(4 * mults[i]));
		end
		host.put(cfg_offset, 16'h0001);
		sample = 16'h3c96;
		repeat (300) @(negedge mclk);
		host.get(result_offset, d, v);
		chk(d, 16'h5ac3);
		host.get(8'h03, d, v);
		chk(d, 16'h0000);
		host.put(cfg_offset, host.start_cfg);
		wait_fresh(n);
		host.get(result_offset, d, v);
		chk(d, 16'h3c96);
		// a reserved period code still measures but never signals a fresh result
		sample = 16'h0f1e;
		host.put(cfg_offset, {3'h0, gain_x2, 1'b0, 4'h4, 6'h00});
		wait_fresh(n);
		chk(16'(n), 16'd400);
		host.get(result_offset, d, v);
		chk(d, 16'h0f1e);
		chk(16'(host.factor_of(gain_x2, it_25)), 16'd1152);
		chk(16'(host.factor_of(gain_x1_8, it_100)), 16'd4608);
		chk(16'(host.factor_of(gain_x2, 4'h4)), 16'h0000);
		chk(16'(host.lux_of(16'd1480, gain_x1_4, it_100) == 3409920), 16'h0001);
		chk(16'(host.limit_of(gain_x2, it_100)), 16'd1887);
		chk(16'(host.limit_of(gain_x1, it_100)), 16'd3775);
		chk(16'(host.needs_comp(16'd5000, gain_x1_8, it_100)), 16'h0001);
		chk(16'(host.needs_comp(16'd1480, gain_x1_4, it_100)), 16'h0000);
		sample = 16'd50;
		host.autorange(g, itc, d);
		chk({10'h000, g, itc}, {10'h000, gain_x2, it_800});
		chk({10'h000, gain_sel, integration_period_sel}, {10'h000, gain_x2, it_800});
		chk(d, 16'd50);
		sample = 16'hffff;
		host.autorange(g, itc, d);
		chk({10'h000, g, itc}, {10'h000, gain_x1_8, it_25});
		chk(d, 16'hffff);
		complete_run;
	end
endmodule
